// >>> src/fio_refresh.sv
/*
 * fio_refresh: scan-end and direct i/o refresh with per-bit forcing,
 * output control on error and an apb register window per slot.
 * assumes apb signals and module pins synchronous to sys_clk; the
 * program drives one scan-end pulse per scan through the control word.
 */

// Summary of operation
// - input refresh overlays forced bits into image
// - output refresh overlays forced bits onto pins
// - output image keeps program results when forced
// - forced value acts after enable is written
// - input forcing works without a module fitted
// - force state survives mode change and reset key
// - stop mode leaves force settings untouched
// - error with hold: clear turns off, hold keeps
// - error without hold turns all outputs off
// - normal refresh only at end of scan
// - direct refresh takes slot and two masks
// - direct refresh touches only mask-one points
// - direct refresh lasts about one millisecond plus
// - every slot owns a fixed block of 64 points
// - base unit takes two slots and 124 points
// - points without terminals act as internal relays
// - force enable kept per bit
// - forced value kept per bit
module fio_refresh #(
    parameter int NSLOT     = fio_pkg::NSLOT_DEF,
    parameter int DR_CYCLES = fio_pkg::DR_CYC
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset_n,
    // register bus
    input  wire fio_pkg::fio_apb_req_t  apb_req,
    output fio_pkg::fio_apb_rsp_t       apb_rsp,
    // i/o modules
    input  wire logic [NSLOT-1:0][63:0] in_pins,
    input  wire logic [NSLOT-1:0]       mod_present,
    input  wire logic                   cpu_err,
    output logic      [NSLOT-1:0][63:0] out_pins
);
    import fio_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state
    logic [NSLOT-1:0][63:0] fen_q, fen_d;
    logic [NSLOT-1:0][63:0] fdat_q, fdat_d;
    logic [NSLOT-1:0][63:0] fval_q, fval_d;
    logic [NSLOT-1:0][63:0] iimg_q, iimg_d;
    logic [NSLOT-1:0][63:0] oimg_q, oimg_d;
    logic [NSLOT-1:0][63:0] out_q, out_d;
    logic                   hold_q, hold_d;
    logic                   ehold_q, ehold_d;
    logic [7:0]             sel_q, sel_d;
    logic [7:0]             drs_q, drs_d;
    logic [31:0]            drh_q, drh_d;
    logic [31:0]            drl_q, drl_d;
    fio_dr_state_t          st_q, st_d;
    logic [31:0]            cnt_q, cnt_d;
    logic [31:0]            rdat_q, rdat_d;
    logic                   serr_q, serr_d;

    // per-slot refresh sources
    logic [NSLOT-1:0]       live;
    logic [NSLOT-1:0][63:0] tmask;
    logic [NSLOT-1:0][63:0] in_frc;
    logic [NSLOT-1:0][63:0] out_frc;
    logic [NSLOT-1:0][63:0] dmask;

    // bus decode
    logic       wr;
    logic       rd;
    logic [7:0] wa;
    logic       hi;
    logic       win_ok;
    int         sx;

    ////////////////////////////////////////////////////////////////////
    // per-slot overlay; every slot is one 64-point block
    for (genvar s = 0; s < NSLOT; s++) begin : g_slot
        // base slots are always fitted
        assign live[s] = (s < BASE_SLOTS) || mod_present[s];
        // the last base slot has only the leftover terminals
        assign tmask[s] = !live[s] ? RST_BITS :
                          (s == BASE_SLOTS - 1) ? BASE_LAST_MASK :
                          ~RST_BITS;
        // no terminal: keep the image value as a relay bit
        assign in_frc[s] = (fen_q[s] & fval_q[s])
                         | (~fen_q[s] & in_pins[s] & tmask[s])
                         | (~fen_q[s] & iimg_q[s] & ~tmask[s]);
        // forcing only reaches the pins; the output image is never rewritten
        assign out_frc[s] = (fen_q[s] & fval_q[s])
                          | (~fen_q[s] & oimg_q[s]);
        assign dmask[s] = (drs_q == 8'(s)) ? {drh_q, drl_q} : RST_BITS;
    end

    ////////////////////////////////////////////////////////////////////
    // apb decode; request taken in the access cycle, data set up before
    // word map: ctrl 00, status 04, direct slot 08, upper mask 0c,
    // lower mask 10, go 14, window select 18; the per-slot pairs
    // (low word first) are force enable 20, force data 28, input
    // image 30, output image 38 and driven pins 40
    // misaligned writes are refused here, so only word accesses land
    assign wr     = apb_req.psel && apb_req.penable && apb_req.pwrite
                 && apb_req.paddr[1:0] == 2'b00;
    assign rd     = apb_req.psel && !apb_req.penable;
    // word address; a 64-bit slot register is a pair of words
    assign wa     = {apb_req.paddr[7:2], 2'b00};
    assign hi     = apb_req.paddr[2];
    // a slot beyond NSLOT has no storage; the window then reads zero
    assign win_ok = sel_q < 8'(NSLOT);
    assign sx     = win_ok ? int'(sel_q) : 0;

    ////////////////////////////////////////////////////////////////////
    // next state of the whole block
    // one process owns every next value, so priority reads top to bottom:
    // software writes, scan refresh, direct refresh, then the error override
    always_comb begin
        fen_d   = fen_q;
        fdat_d  = fdat_q;
        fval_d  = fval_q;
        iimg_d  = iimg_q;
        oimg_d  = oimg_q;
        out_d   = out_q;
        hold_d  = hold_q;
        ehold_d = ehold_q;
        sel_d   = sel_q;
        drs_d   = drs_q;
        drh_d   = drh_q;
        drl_d   = drl_q;
        st_d    = st_q;
        cnt_d   = cnt_q;
        rdat_d  = rdat_q;
        serr_d  = serr_q;

        // software writes; force state only changes here, never by mode
        if (wr) begin
            unique case (wa)
                OFS_CTRL: begin
                    hold_d  = apb_req.pwdata[CTRL_HOLD];
                    ehold_d = apb_req.pwdata[CTRL_EHOLD];
                    if (apb_req.pwdata[CTRL_CLR]) begin
                        fen_d  = '0;
                        fdat_d = '0;
                        fval_d = '0;
                    end
                end
                OFS_DRSLOT: begin
                    // operands frozen while a direct refresh runs
                    if (st_q == DR_IDLE) begin
                        drs_d = apb_req.pwdata[7:0];
                    end
                end
                OFS_DRHI: begin
                    if (st_q == DR_IDLE) begin
                        drh_d = apb_req.pwdata;
                    end
                end
                OFS_DRLO: begin
                    if (st_q == DR_IDLE) begin
                        drl_d = apb_req.pwdata;
                    end
                end
                OFS_SEL: begin
                    sel_d = apb_req.pwdata[7:0];
                end
                OFS_FEN, OFS_FEN + 8'h04: begin
                    if (win_ok) begin
                        fen_d[sx][32*hi +: 32] = apb_req.pwdata;
                        // written data only becomes live on enable
                        fval_d[sx][32*hi +: 32] = fdat_q[sx][32*hi +: 32];
                    end
                end
                OFS_FDAT, OFS_FDAT + 8'h04: begin
                    if (win_ok) begin
                        fdat_d[sx][32*hi +: 32] = apb_req.pwdata;
                    end
                end
                OFS_IIMG, OFS_IIMG + 8'h04: begin
                    if (win_ok) begin
                        iimg_d[sx][32*hi +: 32] = apb_req.pwdata;
                    end
                end
                OFS_OIMG, OFS_OIMG + 8'h04: begin
                    if (win_ok) begin
                        oimg_d[sx][32*hi +: 32] = apb_req.pwdata;
                    end
                end
                default: begin
                end
            endcase
        end

        // a write of any value to go starts the timed module access;
        // a go while busy is dropped, not queued
        if (wr && wa == OFS_DRGO && st_q == DR_IDLE) begin
            st_d  = DR_BUSY;
            cnt_d = 32'(DR_CYCLES - 1);
        end

        // scan-end refresh, after the program has run
        if (wr && wa == OFS_CTRL && apb_req.pwdata[CTRL_SCAN]) begin
            iimg_d = in_frc;
            out_d  = out_frc;
        end

        // direct refresh ends after the module access time
        if (st_q == DR_BUSY) begin
            if (cnt_q == 32'h0000_0000) begin
                st_d = DR_IDLE;
                // masked bits only; a zero mask bit keeps its image and pin
                for (int s = 0; s < NSLOT; s++) begin
                    iimg_d[s] = (in_frc[s] & dmask[s]) | (iimg_d[s] & ~dmask[s]);
                    out_d[s]  = (out_frc[s] & dmask[s]) | (out_d[s] & ~dmask[s]);
                end
            end else begin
                cnt_d = cnt_q - 32'h0000_0001;
            end
        end

        // error overrides the pins; only hold plus emergency hold keeps them
        // it comes last so it beats a refresh in the same cycle
        if (cpu_err) begin
            out_d = (hold_q && ehold_q) ? out_q : '0;
        end

        // read data prepared in the setup cycle
        if (rd) begin
            rdat_d = RST_WORD;
            serr_d = apb_req.paddr[1:0] != 2'b00;
            unique case (wa)
                OFS_CTRL:   rdat_d = {28'h000_0000, 1'b0, ehold_q, hold_q, 1'b0};
                OFS_STATUS: rdat_d = {30'h0000_0000, cpu_err, st_q == DR_BUSY};
                OFS_DRSLOT: rdat_d = {24'h00_0000, drs_q};
                OFS_DRHI:   rdat_d = drh_q;
                OFS_DRLO:   rdat_d = drl_q;
                OFS_DRGO:   rdat_d = RST_WORD;  // go reads back as zero
                OFS_SEL:    rdat_d = {24'h00_0000, sel_q};
                OFS_FEN, OFS_FEN + 8'h04:
                    rdat_d = win_ok ? fen_q[sx][32*hi +: 32] : RST_WORD;
                OFS_FDAT, OFS_FDAT + 8'h04:
                    rdat_d = win_ok ? fdat_q[sx][32*hi +: 32] : RST_WORD;
                OFS_IIMG, OFS_IIMG + 8'h04:
                    rdat_d = win_ok ? iimg_q[sx][32*hi +: 32] : RST_WORD;
                OFS_OIMG, OFS_OIMG + 8'h04:
                    rdat_d = win_ok ? oimg_q[sx][32*hi +: 32] : RST_WORD;
                OFS_OPIN, OFS_OPIN + 8'h04:
                    rdat_d = win_ok ? out_q[sx][32*hi +: 32] : RST_WORD;
                default:    serr_d = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers; reset_n stands for power-up only
    // force state clears only here and by clear-all, so a mode change or
    // reset key outside this block must never pulse reset_n
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fen_q   <= '0;
            fdat_q  <= '0;
            fval_q  <= '0;
            iimg_q  <= '0;
            oimg_q  <= '0;
            out_q   <= '0;
            hold_q  <= 1'b0;
            ehold_q <= 1'b0;
            sel_q   <= 8'h00;
            drs_q   <= 8'h00;
            drh_q   <= RST_WORD;
            drl_q   <= RST_WORD;
            st_q    <= DR_IDLE;
            cnt_q   <= RST_WORD;
            rdat_q  <= RST_WORD;
            serr_q  <= 1'b0;
        end else begin
            fen_q   <= fen_d;
            fdat_q  <= fdat_d;
            fval_q  <= fval_d;
            iimg_q  <= iimg_d;
            oimg_q  <= oimg_d;
            out_q   <= out_d;
            hold_q  <= hold_d;
            ehold_q <= ehold_d;
            sel_q   <= sel_d;
            drs_q   <= drs_d;
            drh_q   <= drh_d;
            drl_q   <= drl_d;
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            rdat_q  <= rdat_d;
            serr_q  <= serr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs; zero wait states since read data is ready at setup
    // pslverr is gated by the access phase so it never shows in setup
    assign apb_rsp.pready  = apb_req.psel && apb_req.penable;
    assign apb_rsp.prdata  = rdat_q;
    assign apb_rsp.pslverr = serr_q && apb_req.psel && apb_req.penable;
    assign out_pins        = out_q;

endmodule  // fio_refresh

// >>> src/fio_pkg.sv
/*
 * fio_pkg: constants, register map and carrier types for the forced
 * i/o overlay refresh block.
 * assumes an apb master with 32-bit data and byte addresses of 8 bits.
 */
package fio_pkg;

    ////////////////////////////////////////////////////////////////////
    // point allocation
    localparam int PTS_PER_SLOT = 64;
    localparam int HALF_PTS     = 32;
    localparam int BASE_SLOTS   = 2;
    localparam int BASE_PTS     = 124;
    localparam int NSLOT_DEF    = 6;
    // terminals of the last base slot: 124 - 64 = 60 low bits
    localparam logic [63:0] BASE_LAST_MASK = 64'h0FFF_FFFF_FFFF_FFFF;

    ////////////////////////////////////////////////////////////////////
    // timing of a direct refresh
    localparam int CLK_MHZ    = 250;
    localparam int DR_TIME_US = 1000;
    localparam int DR_CYC     = DR_TIME_US * CLK_MHZ;

    ////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DRSLOT = 8'h08;
    localparam logic [7:0] OFS_DRHI   = 8'h0C;
    localparam logic [7:0] OFS_DRLO   = 8'h10;
    localparam logic [7:0] OFS_DRGO   = 8'h14;
    localparam logic [7:0] OFS_SEL    = 8'h18;
    localparam logic [7:0] OFS_FEN    = 8'h20;
    localparam logic [7:0] OFS_FDAT   = 8'h28;
    localparam logic [7:0] OFS_IIMG   = 8'h30;
    localparam logic [7:0] OFS_OIMG   = 8'h38;
    localparam logic [7:0] OFS_OPIN   = 8'h40;

    // field positions
    localparam int CTRL_SCAN  = 0;
    localparam int CTRL_HOLD  = 1;
    localparam int CTRL_EHOLD = 2;
    localparam int CTRL_CLR   = 3;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_ERR   = 1;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [63:0] RST_BITS = 64'h0000_0000_0000_0000;

    ////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [7:0]  paddr;
        logic        pwrite;
        logic [31:0] pwdata;
        logic        psel;
        logic        penable;
    } fio_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } fio_apb_rsp_t;

    typedef enum logic {
        DR_IDLE,
        DR_BUSY
    } fio_dr_state_t;

endpackage

// >>> sim/fio_refresh_assertions.sv
/* port checker for fio_refresh, bound at the foot.
   assumes zero-wait apb and the package register map. */
module fio_refresh_assertions
    import fio_pkg::*;
#(
    parameter int NSLOT     = 6,
    parameter int DR_CYCLES = 8
) (
    // clock and reset
    input wire logic                   sys_clk,
    input wire logic                   reset_n,
    // bus and pins
    input wire fio_pkg::fio_apb_req_t  apb_req,
    input wire fio_pkg::fio_apb_rsp_t  apb_rsp,
    input wire logic [NSLOT-1:0][63:0] in_pins,
    input wire logic [NSLOT-1:0]       mod_present,
    input wire logic                   cpu_err,
    input wire logic [NSLOT-1:0][63:0] out_pins
);
    timeunit 1ns;
    timeprecision 100ps;
    logic acc;
    logic ctrl_wr;
    logic go_wr;
    logic both_q;
    int   dr_q;
    assign acc     = apb_req.psel && apb_req.penable;
    assign ctrl_wr = acc && apb_req.pwrite && apb_req.paddr == OFS_CTRL;
    assign go_wr   = acc && apb_req.pwrite && apb_req.paddr == OFS_DRGO;
    // mirror of hold mode and direct timer; a go while busy is dropped
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            both_q <= 1'b0;
            dr_q   <= 0;
        end else begin
            if (ctrl_wr)
                both_q <= apb_req.pwdata[CTRL_HOLD] && apb_req.pwdata[CTRL_EHOLD];
            if (go_wr && dr_q == 0)
                dr_q <= DR_CYCLES;
            else if (dr_q != 0)
                dr_q <= dr_q - 1;
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_ready_now:
        assert property (acc |-> apb_rsp.pready) else $error("no pready");
    chk_ready_idle:
        assert property (!acc |-> !apb_rsp.pready) else $error("stray pready");
    chk_bad_addr:
        assert property (acc && (apb_req.paddr[1:0] != 2'b00 || apb_req.paddr > 8'h44)
            |-> apb_rsp.pslverr) else $error("no slave error");
    chk_busy_flag:
        assert property (apb_req.psel && !apb_req.penable && !apb_req.pwrite
            && apb_req.paddr == OFS_STATUS |=> apb_rsp.prdata[1:0]
            == {$past(cpu_err), $past(dr_q != 0)}) else $error("status wrong");
    chk_err_clear:
        assert property (cpu_err && !both_q |=> out_pins == '0) else $error("pins on");
    chk_err_hold:
        assert property (cpu_err && both_q |=> $stable(out_pins)) else $error("pins moved");
    chk_pins_quiet:
        assert property (!cpu_err && !ctrl_wr && dr_q == 0 |=> $stable(out_pins))
            else $error("pins changed mid scan");
    chk_reset_out:
        assert property ($rose(reset_n) |-> out_pins == '0 && !apb_rsp.pslverr)
            else $error("outputs after reset");
endmodule // fio_refresh_assertions

bind fio_refresh fio_refresh_assertions #(.NSLOT(NSLOT), .DR_CYCLES(DR_CYCLES)) u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .in_pins(in_pins), .mod_present(mod_present), .cpu_err(cpu_err), .out_pins(out_pins));

// >>> sim/fio_io_model.sv
/* model of the expansion i/o modules: fixed input levels per fitted slot.
   assumes six slots; slot 5 is left empty. */
module fio_io_model #(
    parameter logic [63:0] PAT  = 64'h0000_0000_0000_0000,
    parameter logic [5:0]  FITS = 6'h1F
) (
    // clock
    input  wire logic             sys_clk,
    // module side
    output logic      [5:0][63:0] in_pins,
    output logic      [5:0]       mod_present
);
    timeunit 1ns;
    timeprecision 100ps;
    logic toggle_q = 1'b0;
    // an empty slot has no driver: give it a level that flips every cycle
    always_ff @(posedge sys_clk) toggle_q <= !toggle_q;
    always_comb begin
        for (int s = 0; s < 6; s++)
            in_pins[s] = FITS[s] ? PAT ^ 64'(s) : {64{toggle_q}};
        mod_present = FITS;
    end
endmodule // fio_io_model

// >>> sim/fio_refresh_tb.sv
/* self-checking bench for fio_refresh.
   assumes the io model on the pins and a zero-wait apb slave. */
module fio_refresh_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fio_pkg::*;
    localparam logic [63:0] PAT = 64'hA5A5_0F0F_3C3C_9696;
    logic sys_clk, reset_n, cpu_err, serr;
    fio_apb_req_t req;
    fio_apb_rsp_t rsp;
    logic [5:0][63:0] in_pins, out_pins;
    logic [5:0] mod_present;
    logic [31:0] rd, ctl;
    int err_count, n_checks, cyc;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

    fio_refresh #(.NSLOT(6), .DR_CYCLES(8)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .apb_req(req), .apb_rsp(rsp), .in_pins(in_pins), .mod_present(mod_present),
        .cpu_err(cpu_err), .out_pins(out_pins));
    fio_io_model #(.PAT(PAT)) u_io (.sys_clk(sys_clk), .in_pins(in_pins),
        .mod_present(mod_present));
    ////////////////////////////////////////
    // one transfer; the extra idle edge keeps the next setup off this step
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        req <= '{a, w, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do @(posedge sys_clk); while (!rsp.pready);
        rd = rsp.prdata;
        serr = rsp.pslverr;
        req <= '0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0000_0000);
        `CHK(rd, e)
    endtask
    task automatic scan();
        wr(OFS_CTRL, ctl | 32'h0000_0001);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_force_in();
        logic [63:0] p;
        p = PAT ^ 64'd2;
        wr(OFS_SEL, 32'd2);
        wr(OFS_FDAT, 32'h0000_FF00);
        scan();
        rdchk(OFS_IIMG, p[31:0]);
        wr(OFS_FEN, 32'h0000_0FF0);
        scan();
        rdchk(OFS_IIMG, p[31:0] & ~32'h0000_0FF0 | 32'h0000_0F00);
        wr(OFS_FDAT, 32'h0000_0000);
        scan();
        rdchk(OFS_IIMG, p[31:0] & ~32'h0000_0FF0 | 32'h0000_0F00);
        rdchk(OFS_IIMG + 8'h04, p[63:32]);
        $display("done force_in");
    endtask
    task automatic t_force_out();
        wr(OFS_SEL, 32'd3);
        wr(OFS_OIMG, 32'h1234_5678);
        wr(OFS_FDAT, 32'hFFFF_0000);
        wr(OFS_FEN, 32'h00FF_FF00);
        `CHK(out_pins[3], 64'h0)
        scan();
        `CHK(out_pins[3][31:0], 32'h12FF_0078)
        rdchk(OFS_OPIN, 32'h12FF_0078);
        rdchk(OFS_OIMG, 32'h1234_5678);
        $display("done force_out");
    endtask
    task automatic t_absent();
        logic [63:0] p;
        p = PAT ^ 64'd1;
        wr(OFS_SEL, 32'd5);
        wr(OFS_IIMG + 8'h04, 32'hCAFE_0001);
        wr(OFS_FDAT, 32'h0000_0005);
        wr(OFS_FEN, 32'h0000_000F);
        scan();
        rdchk(OFS_IIMG, 32'h0000_0005);
        rdchk(OFS_IIMG + 8'h04, 32'hCAFE_0001);
        // last base slot: top four points have no terminal and keep the image
        wr(OFS_SEL, 32'd1);
        wr(OFS_IIMG + 8'h04, 32'hFFFF_FFFF);
        scan();
        rdchk(OFS_IIMG + 8'h04, {4'hF, p[59:32]});
        $display("done absent");
    endtask
    task automatic t_direct();
        wr(OFS_SEL, 32'd4);
        wr(OFS_OIMG, 32'hFFFF_FFFF);
        wr(OFS_OIMG + 8'h04, 32'hFFFF_FFFF);
        wr(OFS_DRSLOT, 32'd4);
        wr(OFS_DRHI, 32'h8000_0001);
        wr(OFS_DRLO, 32'h0000_0003);
        wr(OFS_DRGO, 32'h0000_0000);
        rdchk(OFS_STATUS, 32'h0000_0001);
        do apb(OFS_STATUS, 1'b0, 32'h0000_0000); while (rd[0]);
        `CHK(out_pins[4], 64'h8000_0001_0000_0003)
        rdchk(OFS_DRHI, 32'h8000_0001);
        $display("done direct");
    endtask
    task automatic t_error();
        for (int m = 0; m < 4; m++) begin
            ctl = 32'(m) << 1;
            scan();
            rdchk(OFS_CTRL, ctl);
            cpu_err <= 1'b1;
            scan();
            rdchk(OFS_STATUS, 32'h0000_0002);
            `CHK(out_pins[3][31:0], (m == 3) ? 32'h12FF_0078 : 32'h0)
            cpu_err <= 1'b0;
            @(posedge sys_clk);
        end
        ctl = 32'h0;
        $display("done error");
    endtask
    task automatic t_misc();
        apb(8'h48, 1'b0, 32'h0);
        `CHK({serr, rd}, {1'b1, 32'h0})
        apb(8'h01, 1'b1, 32'h0);
        `CHK(serr, 1'b1)
        wr(OFS_CTRL, 32'h0000_0008);
        wr(OFS_SEL, 32'd3);
        scan();
        `CHK(out_pins[3][31:0], 32'h1234_5678)
        $display("done misc");
    endtask
    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            $display("BAD %0t timeout", $time);
            final_report();
        end
    end
    initial begin
        req = '0;
        cpu_err = 1'b0;
        ctl = 32'h0;
        reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_force_in();
        t_force_out();
        t_absent();
        t_direct();
        t_error();
        t_misc();
        final_report();
    end
endmodule // fio_refresh_tb
